// >>> rtl/button_filter.sv
// Three-stage synchroniser and debouncer for one panel push-button.
// Assumes an active-high level from the pin, asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module button_filter
  import panel_pkg::*;
#(
  parameter int SETTLE = DEBOUNCE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic raw,
  output logic level,
  output logic pressed
);
  import panel_pkg::*;
  typedef struct packed
  {
    logic [2:0] sync;
    logic [CNT_W-1:0] cnt;
    logic level;
    logic pressed;
  } filt_s;
  filt_s st;
  filt_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.sync = {st.sync[1:0], raw};
    next_st.pressed = 1'b0;
    // Second and third stage must agree before the level may move
    if (st.sync[1] == st.sync[2] && st.sync[2] != st.level)
    begin
      if (st.cnt >= CNT_W'(SETTLE - 1))
      begin
        next_st.level = st.sync[2];
        next_st.pressed = st.sync[2];
        next_st.cnt = CNT_ZERO;
      end
      else
      begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
    else
    begin
      next_st.cnt = CNT_ZERO;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign level = st.level;
  assign pressed = st.pressed;
endmodule : button_filter
`default_nettype wire

// >>> rtl/front_panel_led_status.sv
// Front-panel LED controller: supply, alarm and per-port indicators.
// Assumes status inputs already on sys_clk; buttons come from raw pins.
`timescale 1ns/10ps
`default_nettype none
module front_panel_led_status
  import panel_pkg::*;
#(
  parameter int HOLD = HOLD_CYCLES,
  parameter int BLINK = BLINK_CYCLES,
  parameter int SETTLE = DEBOUNCE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic mode_button,
  input wire logic reset_button,
  input wire logic supply_one_present,
  input wire logic supply_one_good,
  input wire logic supply_two_present,
  input wire logic supply_two_good,
  input wire logic alarm_active,
  input wire logic [NUM_PORTS-1:0] port_link,
  input wire logic [NUM_PORTS-1:0] port_activity,
  input wire logic [NUM_PORTS-1:0] port_full_duplex,
  input wire logic [2*NUM_PORTS-1:0] port_speed,
  output logic [1:0] supply_one_indicator,
  output logic [1:0] supply_two_indicator,
  output logic alarm_led,
  output logic [2*NUM_PORTS-1:0] port_led,
  output logic [1:0] view,
  output logic system_reset
);
  import panel_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    view_e view;
    logic [CNT_W-1:0] blink_cnt;
    logic blink;
    logic [CNT_W-1:0] hold_cnt;
    logic fired;
    logic sys_rst;
    logic [1:0] sup1;
    logic [1:0] sup2;
    logic alarm;
    logic [2*NUM_PORTS-1:0] leds;
  } panel_s;
  panel_s st;
  panel_s next_st;

  logic mode_pressed;
  logic rst_level;

  button_filter #(.SETTLE(SETTLE)) u_mode
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw(mode_button),
    .level(),
    .pressed(mode_pressed)
  );

  button_filter #(.SETTLE(SETTLE)) u_reset
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw(reset_button),
    .level(rst_level),
    .pressed()
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] supply_colour(input logic present, input logic good);
    if (!present)
      supply_colour = LED_OFF;
    else if (good)
      supply_colour = LED_GREEN;
    else
      supply_colour = LED_RED;
  endfunction : supply_colour

  function automatic logic [1:0] port_colour(input view_e v, input logic link, input logic act,
                                            input logic full, input logic [1:0] spd,
                                            input logic blink);
    port_colour = LED_OFF;
    if (link)
    begin
      unique case (v)
        VIEW_STATUS: port_colour = (act && !blink) ? LED_OFF : LED_GREEN;
        VIEW_DUPLEX: port_colour = full ? LED_GREEN : LED_ORANGE;
        VIEW_SPEED:
        begin
          if (spd == SPD_1000)
            port_colour = blink ? LED_GREEN : LED_OFF;
          else if (spd == SPD_100)
            port_colour = LED_GREEN;
          else
            port_colour = LED_ORANGE;
        end
        default: port_colour = LED_OFF;
      endcase
    end
  endfunction : port_colour

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    // One shared blink timebase keeps all blinking LEDs in phase
    if (st.blink_cnt >= CNT_W'(BLINK - 1))
    begin
      next_st.blink_cnt = CNT_ZERO;
      next_st.blink = !st.blink;
    end
    else
    begin
      next_st.blink_cnt = st.blink_cnt + 1'b1;
    end
    if (mode_pressed)
    begin
      unique case (st.view)
        VIEW_STATUS: next_st.view = VIEW_DUPLEX;
        VIEW_DUPLEX: next_st.view = VIEW_SPEED;
        VIEW_SPEED: next_st.view = VIEW_STATUS;
        default: next_st.view = VIEW_STATUS;
      endcase
    end
    // Count only while held; any release restarts the count
    next_st.sys_rst = 1'b0;
    if (!rst_level)
    begin
      next_st.hold_cnt = CNT_ZERO;
      next_st.fired = 1'b0;
    end
    else if (!st.fired)
    begin
      if (st.hold_cnt >= CNT_W'(HOLD - 1))
      begin
        next_st.sys_rst = 1'b1;
        next_st.fired = 1'b1;
      end
      else
      begin
        next_st.hold_cnt = st.hold_cnt + 1'b1;
      end
    end
    next_st.sup1 = supply_colour(supply_one_present, supply_one_good);
    next_st.sup2 = supply_colour(supply_two_present, supply_two_good);
    next_st.alarm = alarm_active;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      next_st.leds[2*i +: 2] = port_colour(st.view, port_link[i], port_activity[i],
                                           port_full_duplex[i], port_speed[2*i +: 2],
                                           st.blink);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0; // Status view is code zero
    else
      st <= next_st;
  end

  assign supply_one_indicator = st.sup1;
  assign supply_two_indicator = st.sup2;
  assign alarm_led = st.alarm;
  assign port_led = st.leds;
  assign view = st.view;
  assign system_reset = st.sys_rst;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence held_full;
    rst_level && st.hold_cnt == CNT_W'(HOLD - 1) && !st.fired;
  endsequence

  chk_reset_after_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    held_full |=> system_reset)
    else $error("reset not raised after full hold");
  chk_reset_needs_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    system_reset |-> $past(rst_level) && st.fired)
    else $error("reset raised without hold");
  chk_supply_colour: assert property (@(posedge sys_clk) disable iff (!nrst)
    ##1 supply_one_indicator == supply_colour($past(supply_one_present), $past(supply_one_good)))
    else $error("supply one colour wrong");
  chk_alarm_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
    alarm_active |=> alarm_led)
    else $error("alarm not lit");
  chk_alarm_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    !alarm_active |=> !alarm_led)
    else $error("alarm lit without alarm");
  chk_view_legal: assert property (@(posedge sys_clk) disable iff (!nrst)
    view != 2'h2)
    else $error("illegal view");
  chk_view_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
    mode_pressed && st.view == VIEW_STATUS |=> st.view == VIEW_DUPLEX)
    else $error("view did not advance");
  chk_view_to_speed: assert property (@(posedge sys_clk) disable iff (!nrst)
    mode_pressed && st.view == VIEW_DUPLEX |=> st.view == VIEW_SPEED)
    else $error("view did not reach speed");
  chk_view_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    mode_pressed && st.view == VIEW_SPEED |=> st.view == VIEW_STATUS)
    else $error("view did not wrap");
  chk_view_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !mode_pressed |=> $stable(st.view))
    else $error("view moved without press");
  chk_nolink_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    !port_link[0] |=> port_led[1:0] == LED_OFF)
    else $error("port lit without link");
  chk_duplex_half: assert property (@(posedge sys_clk) disable iff (!nrst)
    st.view == VIEW_DUPLEX && !mode_pressed && port_link[0] && !port_full_duplex[0]
    |=> port_led[1:0] == LED_ORANGE)
    else $error("half duplex not orange");
  chk_speed_ten: assert property (@(posedge sys_clk) disable iff (!nrst)
    st.view == VIEW_SPEED && !mode_pressed && port_link[0] && port_speed[1:0] == SPD_10
    |=> port_led[1:0] == LED_ORANGE)
    else $error("10 speed not orange");
  chk_blink_period: assert property (@(posedge sys_clk) disable iff (!nrst)
    st.blink_cnt == CNT_W'(BLINK - 1) |=> st.blink != $past(st.blink))
    else $error("blink did not toggle");
endmodule : front_panel_led_status
`default_nettype wire

// >>> rtl/panel_pkg.sv
// Constants and types for the front-panel status display controller.
// Assumes a 40 MHz system clock; shared by the top and its debouncer.
`default_nettype none
package panel_pkg;
  // ----------------------------------------
  // Geometry and timing
  // ----------------------------------------
  localparam int NUM_PORTS = 19;
  localparam int CLK_HZ = 40_000_000;
  localparam int HOLD_SEC = 5;
  localparam int HOLD_CYCLES = HOLD_SEC * CLK_HZ;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
  localparam int CNT_W = 28;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {VIEW_STATUS = 2'h0, VIEW_DUPLEX = 2'h1, VIEW_SPEED = 2'h3} view_e;
  typedef enum logic [1:0] {SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2} speed_e;
  // LED colour code: bit1 red, bit0 green; both lit shows orange
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;
  localparam logic [1:0] LED_ORANGE = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
endpackage : panel_pkg
`default_nettype wire

// >>> verification/button_model.sv
// Behavioural panel push-button with contact bounce.
// Assumes go is a one-cycle strobe set by the bench at a falling edge.
`timescale 1ns/10ps
`default_nettype none
module button_model
(
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] len,
  output logic raw
);
  int n = 0;
  // ----------------------------------------
  // Four cycles of alternating bounce, then a steady hold
  // ----------------------------------------
  // Blips stay shorter than the filter window, so only the hold should count
  always @(negedge sys_clk)
  begin
    if (go && n == 0)
    begin
      n = len + 4;
    end
    if (n > 0)
    begin
      raw = (n > len) ? n[0] : 1'b1;
      n = n - 1;
    end
    else
    begin
      raw = 1'b0;
    end
  end
endmodule : button_model
`default_nettype wire

// >>> verification/test_front_panel_led_status.sv
// Self-checking bench for the front-panel LED controller.
// Assumes short HOLD, BLINK and SETTLE counts; buttons come from button_model.
`timescale 1ns/10ps
`default_nettype none
module test_front_panel_led_status;
  import panel_pkg::*;
  localparam int HOLD_T = 50;
  localparam int BLINK_T = 4;
  localparam int SETTLE_T = 3;
  logic sys_clk = 1'b0, nrst = 1'b0, mgo = 1'b0, rgo = 1'b0, mode_button, reset_button;
  logic [7:0] mlen = 8'h0a, rlen = 8'h0a;
  logic s1p = 1'b0, s1g = 1'b0, s2p = 1'b0, s2g = 1'b0, alarm = 1'b0, sys_rst;
  logic [NUM_PORTS-1:0] link = '0, act = '0, full = '0;
  logic [2*NUM_PORTS-1:0] spd = '0, led;
  logic [1:0] s1led, s2led, view, last_view = 2'h0, cur = 2'h0;
  logic [2:0] exp_q[$];
  logic [2:0] e;
  logic alarm_led;
  int num_errors = 0, total_checks = 0, cycles = 0, seed;
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  button_model mode_u (.sys_clk(sys_clk), .go(mgo), .len(mlen), .raw(mode_button));
  button_model reset_u (.sys_clk(sys_clk), .go(rgo), .len(rlen), .raw(reset_button));
  front_panel_led_status #(.HOLD(HOLD_T), .BLINK(BLINK_T), .SETTLE(SETTLE_T)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .mode_button(mode_button), .reset_button(reset_button),
    .supply_one_present(s1p), .supply_one_good(s1g), .supply_two_present(s2p),
    .supply_two_good(s2g), .alarm_active(alarm), .port_link(link), .port_activity(act),
    .port_full_duplex(full), .port_speed(spd), .supply_one_indicator(s1led),
    .supply_two_indicator(s2led), .alarm_led(alarm_led), .port_led(led), .view(view),
    .system_reset(sys_rst));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  function automatic logic [1:0] sup(input logic p, input logic g);
    return !p ? LED_OFF : (g ? LED_GREEN : LED_RED);
  endfunction : sup
  // Red marks a blinking green, which may read off or green
  function automatic logic [1:0] exp_led(input logic [1:0] v, input int i);
    if (!link[i]) return LED_OFF;
    if (v == VIEW_STATUS) return act[i] ? LED_RED : LED_GREEN;
    if (v == VIEW_DUPLEX) return full[i] ? LED_GREEN : LED_ORANGE;
    return spd[2*i+:2] == SPD_1000 ? LED_RED : (spd[2*i+:2] == SPD_100 ? LED_GREEN : LED_ORANGE);
  endfunction : exp_led
  task automatic check_outputs();
    logic [1:0] x;
    logic good;
    check(s1led === sup(s1p, s1g) && s2led === sup(s2p, s2g), "supply indicator");
    check(alarm_led === alarm, "alarm indicator");
    check(view === cur, "display view");
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      x = exp_led(cur, i);
      good = (x == LED_RED) ? (led[2*i+:2] inside {LED_OFF, LED_GREEN}) : (led[2*i+:2] === x);
      check(good, "port indicator");
    end
  endtask : check_outputs
  task automatic drive_random();
    @(negedge sys_clk);
    {s1p, s1g, s2p, s2g, alarm} = 5'($urandom);
    link = NUM_PORTS'($urandom);
    act = NUM_PORTS'($urandom);
    full = NUM_PORTS'($urandom);
    spd = {6'($urandom), $urandom};
    @(negedge sys_clk);
    check_outputs();
  endtask : drive_random
  task automatic blink_check();
    int g;
    g = 0;
    for (int k = 0; k < 4 * BLINK_T; k++)
    begin
      @(negedge sys_clk);
      check(led === {NUM_PORTS{led[1:0]}}, "shared blink phase");
      g += (led[1:0] == LED_GREEN);
    end
    check(g == 2 * BLINK_T, "blink duty");
  endtask : blink_check
  task automatic press(input logic [7:0] len);
    if (len > 8'(SETTLE_T))
    begin
      cur = (cur == VIEW_STATUS) ? VIEW_DUPLEX : (cur == VIEW_DUPLEX ? VIEW_SPEED : VIEW_STATUS);
      exp_q.push_back({cur, 1'b0});
    end
    mlen <= len;
    mgo <= 1'b1;
    @(negedge sys_clk);
    mgo <= 1'b0;
    repeat (int'(len) + 30) @(negedge sys_clk);
  endtask : press
  task automatic hold_reset(input logic [7:0] len, input logic fires);
    if (fires)
      exp_q.push_back({cur, 1'b1});
    rlen <= len;
    rgo <= 1'b1;
    @(negedge sys_clk);
    rgo <= 1'b0;
    repeat (int'(len) + 30) @(negedge sys_clk);
  endtask : hold_reset
  // ----------------------------------------
  // Event monitor and timeout
  // ----------------------------------------
  always @(negedge sys_clk)
  begin
    if (sys_rst === 1'b1 || view !== last_view)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected view step or reset pulse");
      else
      begin
        e = exp_q.pop_front();
        check({view, sys_rst} === e, "view step or reset pulse");
      end
    end
    last_view = view;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      check(1'b0, "timeout");
      close_out();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = $urandom(32'h6c44b189);
    repeat (20) @(negedge sys_clk);
    check(view === 2'h0 && led === '0 && sys_rst === 1'b0, "reset values");
    nrst = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      repeat (8) drive_random();
      press(8'h0a);
    end
    link = '1;
    act = '1;
    spd = {NUM_PORTS{2'h2}};
    blink_check();
    press(8'h01);
    press(8'h0a);
    press(8'h0a);
    blink_check();
    spd = '0;
    repeat (2) @(negedge sys_clk);
    check_outputs();
    press(8'h0a);
    press(8'h0a);
    full = '0;
    repeat (2) @(negedge sys_clk);
    check_outputs();
    hold_reset(8'h1e, 1'b0);
    hold_reset(8'h78, 1'b1);
    exp_q.push_back(3'h0);
    cur = VIEW_STATUS;
    nrst = 1'b0;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    drive_random();
    check(exp_q.size() == 0, "missing view step or reset pulse");
    close_out();
  end
endmodule : test_front_panel_led_status
`default_nettype wire
